// File: rtl/ipx_pkg.sv
package ipx_pkg;
  // instruction word width (D9..D0)
  localparam int unsigned INSTR_W = 10;
  // accumulator and port width of the 4-bit core
  localparam int unsigned DATA_W  = 4;

  // opcodes; the encodings are not reliably known, so they are parameters
  // of the top module with these defaults and may be overridden
  localparam logic [INSTR_W-1:0] OPC_SET_INT_EN   = 10'h005;
  localparam logic [INSTR_W-1:0] OPC_ARM_PDN      = 10'h05B;
  localparam logic [INSTR_W-1:0] OPC_LOAD_PORT0   = 10'h260;
  localparam logic [INSTR_W-1:0] OPC_LOAD_PORT1   = 10'h261;

  // reset values
  localparam logic              INT_EN_RST = 1'b0;
  localparam logic              ARMED_RST  = 1'b0;
  localparam logic [DATA_W-1:0] ACC_RST    = 4'h0;

  // decoded operation
  typedef enum {
    OP_NONE,
    OP_SET_INT_EN,
    OP_ARM_PDN,
    OP_LOAD_PORT0,
    OP_LOAD_PORT1
  } ipx_op_t;
endpackage

// File: rtl/ipx_dec_if.sv
interface ipx_dec_if;
  import ipx_pkg::*;
  ipx_op_t op;
  logic    known;
  modport dec (output op, output known);
  modport exe (input op, input known);
endinterface

// File: rtl/ipx_decoder.sv
module ipx_decoder
  import ipx_pkg::*;
#(
  parameter logic [INSTR_W-1:0] OpcSetIntEn = OPC_SET_INT_EN,
  parameter logic [INSTR_W-1:0] OpcArmPdn   = OPC_ARM_PDN,
  parameter logic [INSTR_W-1:0] OpcPort0    = OPC_LOAD_PORT0,
  parameter logic [INSTR_W-1:0] OpcPort1    = OPC_LOAD_PORT1
) (
  // instruction in
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic               valid,
  // decoded result
  ipx_dec_if.dec                  dec
);
  // pure compare, one word per instruction so no state is needed
  always_comb begin
    dec.op    = OP_NONE;
    dec.known = 1'b0;
    if (valid) begin
      dec.known = 1'b1;
      if (instr == OpcSetIntEn) dec.op = OP_SET_INT_EN;
      else if (instr == OpcArmPdn) dec.op = OP_ARM_PDN;
      else if (instr == OpcPort0) dec.op = OP_LOAD_PORT0;
      else if (instr == OpcPort1) dec.op = OP_LOAD_PORT1;
      else dec.known = 1'b0;
    end
  end
endmodule

// File: rtl/ipx_exec.sv
// Summary of operation
// - interrupt-enable opcode sets the interrupt enable flag
// - arming opcode validates the next power-down instruction only
// - port zero opcode loads accumulator from port
// - port one opcode loads accumulator from port
module ipx_exec
  import ipx_pkg::*;
#(
  parameter logic [INSTR_W-1:0] OpcSetIntEn = OPC_SET_INT_EN,
  parameter logic [INSTR_W-1:0] OpcArmPdn   = OPC_ARM_PDN,
  parameter logic [INSTR_W-1:0] OpcPort0    = OPC_LOAD_PORT0,
  parameter logic [INSTR_W-1:0] OpcPort1    = OPC_LOAD_PORT1
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // instruction from the sequencer
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic               instrValid,
  // flag and state from the rest of the core
  input  wire logic               intEnClear,
  input  wire logic               powerDownTaken,
  input  wire logic               accWrite,
  input  wire logic [DATA_W-1:0]  accWriteData,
  // input ports
  input  wire logic [DATA_W-1:0]  inputPortZero,
  input  wire logic [DATA_W-1:0]  inputPortOne,
  // results
  output logic                    interruptEnableFlag,
  output logic                    powerDownArmed,
  output logic [DATA_W-1:0]       acc,
  output logic                    opDone,
  output logic                    carryWrite,
  output logic                    skipNext
);
  ipx_dec_if decBus ();

  ipx_decoder #(
    .OpcSetIntEn (OpcSetIntEn),
    .OpcArmPdn   (OpcArmPdn),
    .OpcPort0    (OpcPort0),
    .OpcPort1    (OpcPort1)
  ) uDec (
    .instr (instr),
    .valid (instrValid),
    .dec   (decBus.dec)
  );

  // decoded strobes; the decoder yields at most one op per cycle
  logic              setIntEnOp;
  logic              armPdnOp;
  logic              loadPortZeroOp;
  logic              loadPortOneOp;
  logic              anyOp;

  // interrupt enable flag
  logic              intEn_q;
  logic              intEn_d;

  // power-down arming
  logic              armed_q;
  logic              armed_d;

  // accumulator; next value is a net as each bit has its own driver
  logic [DATA_W-1:0] acc_q;
  wire  logic [DATA_W-1:0] acc_d;

  // completion pulse
  logic              done_q;
  logic              done_d;

  // carry and skip requests
  logic              carry_q;
  logic              carry_d;
  logic              skip_q;
  logic              skip_d;

  // split the enum into strobes so each register reads one plain bit
  always_comb begin
    setIntEnOp     = 1'b0;
    armPdnOp       = 1'b0;
    loadPortZeroOp = 1'b0;
    loadPortOneOp  = 1'b0;
    case (decBus.op)
      OP_SET_INT_EN: begin
        setIntEnOp = 1'b1;
      end
      OP_ARM_PDN: begin
        armPdnOp = 1'b1;
      end
      OP_LOAD_PORT0: begin
        loadPortZeroOp = 1'b1;
      end
      OP_LOAD_PORT1: begin
        loadPortOneOp = 1'b1;
      end
      default: begin
        setIntEnOp = 1'b0;
      end
    endcase
    anyOp = decBus.known;
  end

  // flag next value; set beats a same-cycle clear so no enable is lost
  always_comb begin
    intEn_d = intEn_q;
    if (setIntEnOp) begin
      intEn_d = 1'b1;
    end else if (intEnClear) begin
      intEn_d = 1'b0;
    end
  end

  // flag register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intEn_q <= INT_EN_RST;
    end else begin
      intEn_q <= intEn_d;
    end
  end

  // arming lasts until the core reports a power-down op taken;
  // arming again in the same cycle wins, so a fresh arm is never lost
  always_comb begin
    armed_d = armed_q;
    if (armPdnOp) begin
      armed_d = 1'b1;
    end else if (powerDownTaken) begin
      armed_d = 1'b0;
    end
  end

  // arming register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_q <= ARMED_RST;
    end else begin
      armed_q <= armed_d;
    end
  end

  // accumulator next value per bit; a port load beats a core write,
  // since the op in flight owns the accumulator this cycle
  for (genvar b = 0; b < DATA_W; b++) begin : g_accBit
    assign acc_d[b] = loadPortZeroOp ? inputPortZero[b]
                    : loadPortOneOp  ? inputPortOne[b]
                    : accWrite       ? accWriteData[b]
                    :                  acc_q[b];
  end

  // accumulator register; ports are taken as already synchronous,
  // so an asynchronous pin needs its own synchroniser upstream
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // every op is one word and one cycle, so done follows the decode
  always_comb begin
    done_d = anyOp;
  end

  // completion register; a pulse of exactly one cycle per op
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // these ops never write carry
  always_comb begin
    carry_d = 1'b0;
  end

  // carry request register, kept so the output comes from a flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      carry_q <= 1'b0;
    end else begin
      carry_q <= carry_d;
    end
  end

  // these ops never ask for the next word to be skipped
  always_comb begin
    skip_d = 1'b0;
  end

  // skip request register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
    end
  end

  // outputs straight from the registers above
  assign interruptEnableFlag = intEn_q;
  assign powerDownArmed      = armed_q;
  assign acc                 = acc_q;
  assign opDone              = done_q;
  assign carryWrite          = carry_q;
  assign skipNext            = skip_q;
endmodule

// File: sim/ipx_exec_properties.sv
module ipx_chk import ipx_pkg::*; (
  // top ports, watched only
  input logic clock, rst, instrValid, opDone, carryWrite, skipNext,
  input logic interruptEnableFlag, powerDownArmed,
  input logic [INSTR_W-1:0] instr,
  input logic [DATA_W-1:0] inputPortZero, inputPortOne, acc
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // own decode, so a decoder slip cannot hide
  wire setOp = instrValid && instr == OPC_SET_INT_EN;
  wire armOp = instrValid && instr == OPC_ARM_PDN;
  wire ld0Op = instrValid && instr == OPC_LOAD_PORT0;
  wire ld1Op = instrValid && instr == OPC_LOAD_PORT1;
  wire anyOp = setOp || armOp || ld0Op || ld1Op;
  AST_SET: assert property (setOp |=> interruptEnableFlag)
    else $error("flag not set");
  AST_ARM: assert property (armOp |=> powerDownArmed)
    else $error("not armed");
  AST_LD0: assert property (ld0Op |=> acc == $past(inputPortZero))
    else $error("bad port load");
  AST_LD1: assert property (ld1Op |=> acc == $past(inputPortOne))
    else $error("bad port one load");
  AST_DONE: assert property (anyOp |=> opDone)
    else $error("no done pulse");
  AST_NODONE: assert property (!anyOp |=> !opDone)
    else $error("done without op");
  AST_QUIET: assert property (!carryWrite && !skipNext)
    else $error("carry or skip");
  // main scenarios
  cover property (setOp ##1 ld0Op);
  cover property (armOp ##1 armOp);
  cover property (ld0Op ##1 setOp);
endmodule
bind ipx_exec ipx_chk ipx_chk_inst (.*);

// File: sim/ipx_seq.sv
module ipx_seq import ipx_pkg::*; (
  // choice from the bench, word to the core
  input logic clock,
  input logic [2:0] pick,
  output logic [INSTR_W-1:0] instr,
  output logic instrValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [INSTR_W-1:0] opc [4] = '{OPC_SET_INT_EN, OPC_ARM_PDN,
    OPC_LOAD_PORT0, OPC_LOAD_PORT1};
  initial {instr, instrValid} = '0;
  // one word a cycle; 4 decodes to nothing, 5 drops the qualifier
  always @(posedge clock) begin
    instrValid <= pick != 3'h5;
    instr <= pick == 3'h4 ? 10'h3FF : opc[pick[1:0]];
  end
endmodule

// File: sim/ipx_exec_bench.sv
module ipx_exec_bench import ipx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus, outputs and model state
  logic clock = 1'h0, rst = 1'h1, intEnClear, powerDownTaken, accWrite;
  logic instrValid, interruptEnableFlag, powerDownArmed, opDone;
  logic carryWrite, skipNext;
  logic [DATA_W-1:0] accWriteData, inputPortZero, inputPortOne, acc;
  logic [INSTR_W-1:0] instr;
  logic [2:0] pick;
  logic [31:0] r = 32'h9FA2FE39;
  int fails = 0, tests_run = 0;
  bit expFlag, expArm, expDone;
  bit [3:0] expAcc;
  ipx_exec ipx_exec_inst (.*);
  ipx_seq ipx_seq_inst (.*);
  initial forever #5 clock = ~clock;
  task wrap_up;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // reference model; later lines win, as an op beats clear or write
  always @(posedge clock or posedge rst) begin
    if (rst) {expFlag, expArm, expDone, expAcc} = '0;
    else begin
      expDone = 0;
      if (intEnClear) expFlag = 0;
      if (powerDownTaken) expArm = 0;
      if (accWrite) expAcc = accWriteData;
      if (instrValid) case (instr)
        OPC_SET_INT_EN: {expFlag, expDone} = 2'h3;
        OPC_ARM_PDN: {expArm, expDone} = 2'h3;
        OPC_LOAD_PORT0: {expAcc, expDone} = {inputPortZero, 1'h1};
        OPC_LOAD_PORT1: {expAcc, expDone} = {inputPortOne, 1'h1};
      endcase
    end
  end
  // compare at mid cycle, once the edge has settled
  always @(negedge clock) if (!rst) begin
    tests_run++;
    if ({interruptEnableFlag, powerDownArmed, acc, opDone, carryWrite,
        skipNext} !== {expFlag, expArm, expAcc, expDone, 2'h0}) begin
      fails++;
      $display("wrong value at %0t: outputs differ from model", $time);
    end
  end
  // random traffic every cycle, one reset in mid-run
  initial begin
    {pick, intEnClear, powerDownTaken, accWrite, accWriteData} = '0;
    {inputPortZero, inputPortOne} = '0;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clock);
      r ^= r << 13;
      r ^= r >> 17;
      r ^= r << 5;
      {pick, intEnClear, powerDownTaken, accWrite, accWriteData,
        inputPortZero, inputPortOne} <= r[17:0];
      rst <= i == 999;
    end
    wrap_up;
  end
  // watchdog well past the 2003 cycles needed
  initial begin
    #40000;
    fails++;
    wrap_up;
  end
endmodule
